// ### logic/parity_report.sv
// data parity detection and reporting for both ports of the bridge
// Function
// - primary target posted write: parity pin after two
// - that error sets primary detected parity bit
// - forward bad parity, complete transfer normally
// - upstream posted error: secondary pin, bit, forward
// - secondary target report sets secondary master bit
// - downstream posted report raises gated system error
// - upstream primary posted report: master bit, gated system error
// - system error also sets signaled system error
// - no system error for forwarded parity errors
// - primary detected bit only for three cases
// - secondary detected bit for three cases
// - primary master bit only as enabled master
// - secondary master bit only as enabled master
// - primary parity pin only target write, master read, secondary delayed write report
// - secondary report on delayed write drives primary pin
`timescale 1ns/1ps
module parity_report
  import parity_rpt_pkg::*;
(
  input  wire logic                              clk,                          // 50 MHz clock
  input  wire logic                              rst_n,                        // async reset, active low
  input  wire logic [parity_rpt_pkg::ADDR_W-1:0] reg_addr,                     // register index
  input  wire logic [parity_rpt_pkg::DATA_W-1:0] reg_wdata,                    // write data
  input  wire logic                              reg_wr,                       // write strobe
  input  wire logic                              reg_rd,                       // read strobe
  output logic      [parity_rpt_pkg::DATA_W-1:0] reg_rdata,                    // read data, next cycle
  input  wire parity_rpt_pkg::phase_s            p_phase,                      // primary data phase
  input  wire parity_rpt_pkg::phase_s            s_phase,                      // secondary data phase
  input  wire logic                              primary_parity_err_n_in,      // primary pin level
  output logic                                   primary_parity_err_n_out,     // primary pin drive
  output logic                                   primary_parity_err_n_oe,      // primary pin enable
  input  wire logic                              secondary_parity_err_n_in,    // secondary pin level
  output logic                                   secondary_parity_err_n_out,   // secondary pin drive
  output logic                                   secondary_parity_err_n_oe,    // secondary pin enable
  output logic                                   primary_system_err_n_out,     // open-drain drive level
  output logic                                   primary_system_err_n_oe,      // open-drain enable
  output logic                                   fwd_bad_par_to_s,             // poison data to secondary
  output logic                                   fwd_bad_par_to_p              // poison data to primary
);
  logic [1:0]        rst_q_ff;
  logic              rst_sync_n;
  logic [DATA_W-1:0] cmd_ff;
  logic [DATA_W-1:0] bctl_ff;
  logic [DATA_W-1:0] sdis_ff;
  pstat_s            pstat_ff;
  pstat_s            nxt_pstat;
  sstat_s            sstat_ff;
  sstat_s            nxt_sstat;
  logic [1:0]        perr_q1_ff;
  logic [1:0]        perr_q2_ff;
  phase_s            p_dly;
  phase_s            s_dly;
  logic              p_resp, s_resp, serr_en, pw_par_dis;
  logic              p_tgt_wr_err, p_mst_rd_err, s_tgt_wr_err, s_mst_rd_err;
  logic              p_rep, s_rep, p_det_set, s_det_set, p_mdp_set, s_mdp_set;
  logic              serr_dn, serr_up, serr_req;
  logic [1:0]        perr_req;
  logic [1:0]        perr_d1_ff;
  pin_state_e        pin_st_ff [2];
  logic [1:0]        pin_out_ff;
  logic [1:0]        pin_oe_ff;
  logic [1:0]        pin_in;

  // every check samples on the one clock and sleeps until the reset copy is released
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q_ff <= 2'h0;
    end else begin
      rst_q_ff <= {rst_q_ff[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_q_ff[1];

  assign p_resp     = cmd_ff[CMD_PRESP_BIT];
  assign serr_en    = cmd_ff[CMD_SERREN_BIT];
  assign s_resp     = bctl_ff[BCTL_SRESP_BIT];
  assign pw_par_dis = sdis_ff[SDIS_PWPAR_BIT];
  assign pin_in     = {secondary_parity_err_n_in, primary_parity_err_n_in};

  // pin levels come from the other clock world; second stage alone is read
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      perr_q1_ff <= 2'h3;
      perr_q2_ff <= 2'h3;
    end else begin
      perr_q1_ff <= pin_in;
      perr_q2_ff <= perr_q1_ff;
    end
  end

  // our master phases wait until the target's report shows past the synchroniser
  // trade-off: a short copy of each phase is cheaper than tracking every open transfer
  phase_delay #(.WIDTH($bits(phase_s)), .DEPTH(REPORT_LAG)) u_p_dly (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .d     (p_phase),
    .q     (p_dly)
  );
  phase_delay #(.WIDTH($bits(phase_s)), .DEPTH(REPORT_LAG)) u_s_dly (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .d     (s_phase),
    .q     (s_dly)
  );

  // errors we detect ourselves on each bus
  assign p_tgt_wr_err = p_phase.valid && !p_phase.master && p_phase.downstream &&
                        p_phase.kind != XFER_READ && p_phase.par_err;
  assign p_mst_rd_err = p_phase.valid && p_phase.master && !p_phase.downstream &&
                        p_phase.kind == XFER_READ && p_phase.par_err;
  assign s_tgt_wr_err = s_phase.valid && !s_phase.master && !s_phase.downstream &&
                        s_phase.kind != XFER_READ && s_phase.par_err;
  assign s_mst_rd_err = s_phase.valid && s_phase.master && s_phase.downstream &&
                        s_phase.kind == XFER_READ && s_phase.par_err;

  // errors reported by the far target while we were master
  assign p_rep = p_dly.valid && p_dly.master && !perr_q2_ff[0];
  assign s_rep = s_dly.valid && s_dly.master && !perr_q2_ff[1];

  // detected bits ignore the response enables
  assign p_det_set = p_tgt_wr_err || p_mst_rd_err;
  assign s_det_set = s_tgt_wr_err || s_mst_rd_err;
  assign p_mdp_set = p_resp && ((p_phase.valid && p_phase.master && p_phase.par_err) || p_rep);
  assign s_mdp_set = s_resp && ((s_phase.valid && s_phase.master && s_phase.par_err) || s_rep);

  // parity pin requests, each needs its own bus response enable
  // a cross report is raised on the initiator's bus, which never saw the error itself
  assign perr_req[0] = p_resp && (p_tgt_wr_err || p_mst_rd_err ||
                       (s_rep && s_dly.kind == XFER_DELAYED && s_dly.downstream &&
                        s_resp && !s_dly.fwd_err));
  assign perr_req[1] = s_resp && (s_tgt_wr_err || s_mst_rd_err ||
                       (p_rep && p_dly.kind == XFER_DELAYED && !p_dly.downstream &&
                        p_resp && !p_dly.fwd_err));

  // the initiator already knows of a forwarded error, so only fresh ones escalate
  assign serr_dn  = s_rep && s_dly.kind == XFER_POSTED && !s_dly.fwd_err && !pw_par_dis;
  assign serr_up  = p_rep && p_dly.kind == XFER_POSTED && !p_dly.fwd_err;
  assign serr_req = serr_en && p_resp && s_resp && (serr_dn || serr_up);

  // parity pin drivers: low two cycles after the phase, then one cycle driven high
  genvar b;
  generate
    for (b = 0; b < 2; b++) begin : g_pin
      always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          perr_d1_ff[b] <= 1'b0;
          pin_st_ff[b]  <= PIN_IDLE;
          pin_out_ff[b] <= 1'b1;
          pin_oe_ff[b]  <= 1'b0;
        end else begin
          perr_d1_ff[b] <= perr_req[b];
          // a request in any state restarts the low phase, so errors back to back keep the pin low
          case (pin_st_ff[b])
            PIN_IDLE, PIN_LOW, PIN_HIGH: begin
              if (perr_d1_ff[b]) begin
                pin_st_ff[b]  <= PIN_LOW;
                pin_out_ff[b] <= 1'b0;
                pin_oe_ff[b]  <= 1'b1;
              end else if (pin_st_ff[b] == PIN_LOW) begin
                pin_st_ff[b]  <= PIN_HIGH;
                pin_out_ff[b] <= 1'b1;
                pin_oe_ff[b]  <= 1'b1;
              end else begin
                pin_st_ff[b]  <= PIN_IDLE;
                pin_out_ff[b] <= 1'b1;
                pin_oe_ff[b]  <= 1'b0;
              end
            end
            default: begin
              pin_st_ff[b]  <= PIN_IDLE;
              pin_out_ff[b] <= 1'b1;
              pin_oe_ff[b]  <= 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate

  assign primary_parity_err_n_out   = pin_out_ff[0];
  assign primary_parity_err_n_oe    = pin_oe_ff[0];
  assign secondary_parity_err_n_out = pin_out_ff[1];
  assign secondary_parity_err_n_oe  = pin_oe_ff[1];

  // the secondary pin only goes low for an enabled cause; downstream delayed write reports land on the primary pin
  a_s_perr_cause: assert property ((!secondary_parity_err_n_out && secondary_parity_err_n_oe) |->
                                   $past(perr_req[1], 2))
    else $error("secondary parity pin low without enabled cause");
  a_dw_pin: assert property ((p_resp && s_resp && s_rep && s_dly.kind == XFER_DELAYED && s_dly.downstream &&
                             !s_dly.fwd_err) |-> ##2 (!primary_parity_err_n_out && primary_parity_err_n_oe))
    else $error("primary parity pin missing for refused delayed write");

  // system error is a one-cycle open-drain pulse
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      primary_system_err_n_out <= 1'b1;
      primary_system_err_n_oe  <= 1'b0;
    end else begin
      primary_system_err_n_out <= !serr_req;
      primary_system_err_n_oe  <= serr_req;
    end
  end

  // escalation fires for fresh target reports and stays quiet for masked or forwarded ones
  a_serr_dn_fire: assert property ((serr_en && p_resp && s_resp && !pw_par_dis && s_rep &&
                                    s_dly.kind == XFER_POSTED && !s_dly.fwd_err) |=> !primary_system_err_n_out)
    else $error("system error missing for downstream posted report");
  a_serr_up_fire: assert property ((serr_en && p_resp && s_resp && p_rep &&
                                    p_dly.kind == XFER_POSTED && !p_dly.fwd_err) |=> !primary_system_err_n_out)
    else $error("system error missing for upstream posted report");
  a_serr_masked: assert property ((pw_par_dis && !p_rep) |=> primary_system_err_n_out)
    else $error("system error despite posted write event disable");
  a_serr_no_fwd_dn: assert property ((s_rep && s_dly.fwd_err && !p_rep) |=> primary_system_err_n_out)
    else $error("system error for forwarded downstream error");

  // bad parity rides along with the data; the transfer itself completes normally
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fwd_bad_par_to_s <= 1'b0;
      fwd_bad_par_to_p <= 1'b0;
    end else begin
      fwd_bad_par_to_s <= (p_tgt_wr_err && p_phase.kind == XFER_POSTED) || p_mst_rd_err;
      fwd_bad_par_to_p <= (s_tgt_wr_err && s_phase.kind == XFER_POSTED) || s_mst_rd_err;
    end
  end

  // upstream poisoning mirrors the downstream check further below
  a_fwd_to_p: assert property ((s_tgt_wr_err && s_phase.kind == XFER_POSTED) |=> fwd_bad_par_to_p)
    else $error("bad parity not forwarded to primary");

  // control registers steer every gate above
  // limitation: only the low bits steer logic; the rest of each word is kept for software
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cmd_ff  <= REG_RST;
      bctl_ff <= REG_RST;
      sdis_ff <= REG_RST;
    end else if (reg_wr) begin
      if (reg_addr == CMD_OFS)  cmd_ff  <= reg_wdata;
      if (reg_addr == BCTL_OFS) bctl_ff <= reg_wdata;
      if (reg_addr == SDIS_OFS) sdis_ff <= reg_wdata;
    end
  end

  // write one to clear; a set in the same cycle wins so no event is lost
  always_comb begin
    nxt_pstat = pstat_ff;
    nxt_sstat = sstat_ff;
    if (reg_wr && reg_addr == PSTAT_OFS) begin
      nxt_pstat.mdp      = pstat_ff.mdp && !reg_wdata[PST_MDP_BIT];
      nxt_pstat.sig_serr = pstat_ff.sig_serr && !reg_wdata[PST_SSERR_BIT];
      nxt_pstat.det_par  = pstat_ff.det_par && !reg_wdata[PST_DET_BIT];
    end
    if (reg_wr && reg_addr == SSTAT_OFS) begin
      nxt_sstat.mdp     = sstat_ff.mdp && !reg_wdata[SST_MDP_BIT];
      nxt_sstat.det_par = sstat_ff.det_par && !reg_wdata[SST_DET_BIT];
    end
    nxt_pstat.mdp      = nxt_pstat.mdp || p_mdp_set;
    nxt_pstat.sig_serr = nxt_pstat.sig_serr || serr_req;
    nxt_pstat.det_par  = nxt_pstat.det_par || p_det_set;
    nxt_sstat.mdp      = nxt_sstat.mdp || s_mdp_set;
    nxt_sstat.det_par  = nxt_sstat.det_par || s_det_set;
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pstat_ff <= '0;
      sstat_ff <= '0;
    end else begin
      pstat_ff <= nxt_pstat;
      sstat_ff <= nxt_sstat;
    end
  end

  // status bits rise only for a listed cause, and target reports reach the master bits
  a_s_det_only: assert property ($rose(sstat_ff.det_par) |-> $past(s_det_set))
    else $error("secondary detected parity bit set without cause");
  a_p_mdp_rep: assert property ((p_rep && p_resp) |=> pstat_ff.mdp)
    else $error("primary master parity bit missed target report");
  a_s_mdp_rep: assert property ((s_rep && s_resp) |=> sstat_ff.mdp)
    else $error("secondary master parity bit missed target report");

  // read data only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= REG_RST;
    end else if (reg_rd) begin
      case (reg_addr)
        CMD_OFS:   reg_rdata <= cmd_ff;
        BCTL_OFS:  reg_rdata <= bctl_ff;
        SDIS_OFS:  reg_rdata <= sdis_ff;
        PSTAT_OFS: reg_rdata <= {5'h00, pstat_ff};
        SSTAT_OFS: reg_rdata <= {6'h00, sstat_ff};
        default:   reg_rdata <= REG_RST;
      endcase
    end else begin
      reg_rdata <= REG_RST;
    end
  end

  // checks
  a_p_perr_timing: assert property (perr_req[0] |-> ##2 (!primary_parity_err_n_out && primary_parity_err_n_oe))
    else $error("primary parity pin not low two cycles after error");
  a_p_perr_cause: assert property ((!primary_parity_err_n_out && primary_parity_err_n_oe) |-> $past(perr_req[0], 2))
    else $error("primary parity pin low without enabled cause");
  a_p_det_set: assert property (p_det_set |=> pstat_ff.det_par)
    else $error("primary detected parity bit not set");
  a_p_det_only: assert property ($rose(pstat_ff.det_par) |-> $past(p_det_set))
    else $error("primary detected parity bit set without cause");
  a_fwd_bad_par: assert property ((p_tgt_wr_err && p_phase.kind == XFER_POSTED) |=> fwd_bad_par_to_s)
    else $error("bad parity not forwarded to secondary");
  a_s_perr_timing: assert property ((s_resp && s_tgt_wr_err) |-> ##2 (!secondary_parity_err_n_out && secondary_parity_err_n_oe))
    else $error("secondary parity pin not low two cycles after error");
  a_s_det_set: assert property (s_det_set |=> sstat_ff.det_par)
    else $error("secondary detected parity bit not set");
  a_s_mdp_gate: assert property ($rose(sstat_ff.mdp) |-> $past(s_resp))
    else $error("secondary master parity bit set while disabled");
  a_p_mdp_gate: assert property ($rose(pstat_ff.mdp) |-> $past(p_resp))
    else $error("primary master parity bit set while disabled");
  a_serr_gate: assert property (!primary_system_err_n_out |-> $past(serr_en && p_resp && s_resp))
    else $error("system error without all enables");
  a_serr_sig: assert property (!primary_system_err_n_out |-> pstat_ff.sig_serr)
    else $error("system error without signaled bit");
  a_serr_no_fwd: assert property ((p_rep && p_dly.fwd_err && !s_rep) |=> primary_system_err_n_out)
    else $error("system error for forwarded parity error");
  a_dw_report: assert property ((perr_req[0] && !p_tgt_wr_err && !p_mst_rd_err) |-> s_rep && p_resp)
    else $error("primary parity pin request without delayed write report");
  a_status_hold: assert property ((pstat_ff.det_par && !(reg_wr && reg_addr == PSTAT_OFS)) |=> pstat_ff.det_par)
    else $error("primary detected bit lost without clear");

  c_p_perr: cover property (!primary_parity_err_n_out ##1 primary_parity_err_n_oe ##1 !primary_parity_err_n_oe);
  c_serr: cover property (!primary_system_err_n_out);
  c_s_mdp: cover property ($rose(sstat_ff.mdp));
  c_set_clear: cover property (p_det_set && reg_wr && reg_addr == PSTAT_OFS);
  c_dw_report: cover property (p_resp && s_rep && s_dly.kind == XFER_DELAYED);
endmodule

// ### logic/parity_rpt_pkg.sv
// shared constants, register map and carrier types for the parity reporting block
package parity_rpt_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  // register word offsets
  localparam logic [ADDR_W-1:0] CMD_OFS   = 3'h0;
  localparam logic [ADDR_W-1:0] BCTL_OFS  = 3'h1;
  localparam logic [ADDR_W-1:0] SDIS_OFS  = 3'h2;
  localparam logic [ADDR_W-1:0] PSTAT_OFS = 3'h3;
  localparam logic [ADDR_W-1:0] SSTAT_OFS = 3'h4;
  // field positions
  localparam int CMD_PRESP_BIT = 0;
  localparam int CMD_SERREN_BIT = 1;
  localparam int BCTL_SRESP_BIT = 0;
  localparam int SDIS_PWPAR_BIT = 0;
  localparam int PST_MDP_BIT = 0;
  localparam int PST_SSERR_BIT = 1;
  localparam int PST_DET_BIT = 2;
  localparam int SST_MDP_BIT = 0;
  localparam int SST_DET_BIT = 1;
  // reset values
  localparam logic [DATA_W-1:0] REG_RST = 8'h00;
  // cycle counts
  localparam int PERR_DLY = 2;
  localparam int SYNC_DLY = 2;
  localparam int REPORT_LAG = PERR_DLY + SYNC_DLY;

  typedef enum logic [1:0] {XFER_READ, XFER_POSTED, XFER_DELAYED} xfer_e;
  typedef enum logic [1:0] {PIN_IDLE, PIN_LOW, PIN_HIGH} pin_state_e;

  // one data phase seen on one bus, given by the bridge core
  typedef struct packed {
    logic  valid;
    xfer_e kind;
    logic  downstream;
    logic  master;
    logic  par_err;
    logic  fwd_err;
  } phase_s;

  typedef struct packed {
    logic det_par;
    logic sig_serr;
    logic mdp;
  } pstat_s;

  typedef struct packed {
    logic det_par;
    logic mdp;
  } sstat_s;
endpackage

// ### logic/phase_delay.sv
// fixed-length delay line whose output comes from a register
`timescale 1ns/1ps
module phase_delay #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,   // system clock
  input  wire logic             rst_n, // synchronised reset, active low
  input  wire logic [WIDTH-1:0] d,     // word in
  output logic      [WIDTH-1:0] q      // word DEPTH cycles later
);
  logic [WIDTH-1:0] stage_ff [DEPTH];

  // one register per stage
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_stage
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stage_ff[i] <= '0;
        end else begin
          stage_ff[i] <= (i == 0) ? d : stage_ff[(i == 0) ? 0 : i-1];
        end
      end
    end
  endgenerate

  assign q = stage_ff[DEPTH-1];
endmodule

// ### verification/far_side_agent.sv
// behavioural far-side targets on both buses that report parity errors on their pins
`timescale 1ns/1ps
module far_side_agent (
  input  wire logic       clk,        // 50 MHz clock
  input  wire logic       rst_n,      // reset, active low
  input  wire logic       report_p,   // primary target saw bad data in this data phase
  input  wire logic       report_s,   // secondary target saw bad data in this data phase
  output logic            pull_p_low, // high while pulling the primary parity pin low
  output logic            pull_s_low  // high while pulling the secondary parity pin low
);
  logic [1:0] dly_ff;

  // report is driven two cycles after the data phase, for exactly one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_ff     <= 2'h0;
      pull_p_low <= 1'b0;
      pull_s_low <= 1'b0;
    end else begin
      dly_ff     <= {report_p, report_s};
      pull_p_low <= dly_ff[1];
      pull_s_low <= dly_ff[0];
    end
  end
endmodule

// ### verification/testbench.sv
// self-checking bench for the parity detection and reporting block
`timescale 1ns/1ps
module testbench;
  import parity_rpt_pkg::*;
  localparam logic [7:0] P_DET = 8'h01 << PST_DET_BIT;
  localparam logic [7:0] P_SIG = 8'h01 << PST_SSERR_BIT;
  localparam logic [7:0] P_MDP = 8'h01 << PST_MDP_BIT;
  localparam logic [7:0] S_DET = 8'h01 << SST_DET_BIT;
  localparam logic [7:0] S_MDP = 8'h01 << SST_MDP_BIT;
  logic       clk, rst_n, reg_wr, reg_rd, rep_p, rep_s, pull_p, pull_s;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  phase_s     p_phase, s_phase;
  logic       p_out, p_oe, s_out, s_oe, se_out, se_oe, fwd_s, fwd_p;
  int         fails, n_checks;
  wire        p_lvl = ~pull_p & (~p_oe | p_out); // pulled up when nobody drives
  wire        s_lvl = ~pull_s & (~s_oe | s_out);

  parity_report u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .p_phase(p_phase), .s_phase(s_phase),
    .primary_parity_err_n_in(p_lvl), .primary_parity_err_n_out(p_out), .primary_parity_err_n_oe(p_oe),
    .secondary_parity_err_n_in(s_lvl), .secondary_parity_err_n_out(s_out), .secondary_parity_err_n_oe(s_oe),
    .primary_system_err_n_out(se_out), .primary_system_err_n_oe(se_oe),
    .fwd_bad_par_to_s(fwd_s), .fwd_bad_par_to_p(fwd_p));

  far_side_agent u_far (.clk(clk), .rst_n(rst_n), .report_p(rep_p), .report_s(rep_s),
    .pull_p_low(pull_p), .pull_s_low(pull_s));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, exp);
  endtask

  // one data phase; targets report when the bridge masters a clean phase
  task automatic run(input logic on_p, input xfer_e k, input logic dn, ms, pe, fw, input logic [1:0] efwd,
                     input logic [1:0] epin, input logic eserr, ep6, input logic [7:0] epst, esst);
    phase_s ph;
    ph = '{1'b1, k, dn, ms, pe, fw};
    @(posedge clk);
    if (on_p) p_phase <= ph;
    else s_phase <= ph;
    rep_p <= on_p & ms & ~pe;
    rep_s <= ~on_p & ms & ~pe;
    @(posedge clk);
    p_phase <= '0;
    s_phase <= '0;
    rep_p <= 1'b0;
    rep_s <= 1'b0;
    #1 if (pe) chk("fwd", 8'({fwd_s, fwd_p}), 8'(efwd));
    @(posedge clk);
    #1 chk("pin low", 8'({p_oe & ~p_out, s_oe & ~s_out}), 8'(epin));
    repeat (3) @(posedge clk);
    #1 chk("syserr", 8'({se_oe, se_out}), eserr ? 8'h02 : 8'h01);
    @(posedge clk);
    #1 chk("pin low late", 8'(p_oe & ~p_out), 8'(ep6));
    // status holds through a zero write and clears on ones
    wr(PSTAT_OFS, 8'h00);
    rd(PSTAT_OFS, epst);
    rd(SSTAT_OFS, esst);
    wr(PSTAT_OFS, 8'hFF);
    wr(SSTAT_OFS, 8'hFF);
    rd(PSTAT_OFS, 8'h00);
    rd(SSTAT_OFS, 8'h00);
  endtask

  // reset values, and an unmapped write that must leave every word alone
  task automatic after_reset;
    wr(3'h7, 8'hFF);
    for (int i = 0; i < 8; i++) rd(3'(i), 8'h00);
  endtask

  // errors the bridge finds itself, with the response enables on and then off
  task automatic own_detect;
    wr(CMD_OFS, 8'h01);
    wr(BCTL_OFS, 8'h01);
    rd(CMD_OFS, 8'h01);
    run(1, XFER_POSTED, 1, 0, 1, 0, 2'b10, 2'b10, 0, 0, P_DET, 0);
    run(1, XFER_DELAYED, 1, 0, 1, 0, 2'b00, 2'b10, 0, 0, P_DET, 0);
    run(1, XFER_READ, 0, 1, 1, 0, 2'b10, 2'b10, 0, 0, P_DET | P_MDP, 0);
    run(1, XFER_POSTED, 0, 1, 1, 0, 2'b00, 2'b00, 0, 0, P_MDP, 0);
    run(0, XFER_POSTED, 0, 0, 1, 0, 2'b01, 2'b01, 0, 0, 0, S_DET);
    run(0, XFER_READ, 1, 1, 1, 0, 2'b01, 2'b01, 0, 0, 0, S_DET | S_MDP);
    wr(CMD_OFS, 8'h00);
    wr(BCTL_OFS, 8'h00);
    run(1, XFER_POSTED, 1, 0, 1, 0, 2'b10, 2'b00, 0, 0, P_DET, 0);
    run(0, XFER_POSTED, 0, 0, 1, 0, 2'b01, 2'b00, 0, 0, 0, S_DET);
  endtask

  // far targets report errors while the bridge masters the transfer
  task automatic target_reports;
    wr(CMD_OFS, 8'h03);
    wr(BCTL_OFS, 8'h01);
    run(0, XFER_POSTED, 1, 1, 0, 0, 2'b00, 2'b00, 1, 0, P_SIG, S_MDP);
    run(1, XFER_POSTED, 0, 1, 0, 0, 2'b00, 2'b00, 1, 0, P_SIG | P_MDP, 0);
    run(0, XFER_POSTED, 1, 1, 0, 1, 2'b00, 2'b00, 0, 0, 0, S_MDP);
    run(0, XFER_DELAYED, 1, 1, 0, 0, 2'b00, 2'b00, 0, 1, 0, S_MDP);
  endtask

  // the posted write event disable masks only the downstream escalation
  task automatic event_disable;
    wr(SDIS_OFS, 8'h01);
    run(0, XFER_POSTED, 1, 1, 0, 0, 2'b00, 2'b00, 0, 0, 0, S_MDP);
    run(1, XFER_POSTED, 0, 1, 0, 0, 2'b00, 2'b00, 1, 0, P_SIG | P_MDP, 0);
    wr(SDIS_OFS, 8'h00);
  endtask

  // each response enable missing in turn silences what depends on it
  task automatic response_gating;
    wr(BCTL_OFS, 8'h00);
    run(0, XFER_POSTED, 1, 1, 0, 0, 2'b00, 2'b00, 0, 0, 0, 0);
    run(1, XFER_POSTED, 0, 1, 0, 0, 2'b00, 2'b00, 0, 0, P_MDP, 0);
    wr(CMD_OFS, 8'h02);
    wr(BCTL_OFS, 8'h01);
    run(1, XFER_POSTED, 0, 1, 0, 0, 2'b00, 2'b00, 0, 0, 0, 0);
  endtask

  // hang guard, far above the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    test_done;
  end

  initial begin
    rst_n = 1'b0;
    {reg_wr, reg_rd, rep_p, rep_s} = 4'h0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    p_phase = '0;
    s_phase = '0;
    fails = 0;
    n_checks = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    after_reset;
    own_detect;
    target_reports;
    event_disable;
    response_gating;
    test_done;
  end
endmodule
